// >>> inc/prio_chain_pkg.sv
package prio_chain_pkg;
  localparam int HW_LEVELS     = 4;
  localparam int SW_LEVELS     = 4;
  localparam int ALL_LEVELS    = 8;
  localparam int CHANNELS      = 32;
  localparam int DEV_PER_LEVEL = 8;
  localparam int ADDR_W        = 6;
  localparam int CHAN_W        = 5;
  localparam logic [ADDR_W-1:0] TRAP_BASE = 6'h20;
  localparam int SW_CHAN_BASE  = 0;
  localparam int GRANT_HOLD    = 2;
endpackage

// >>> inc/prio_chain_if.sv
`timescale 1ns/1ns
interface prio_chain_if;
  import prio_chain_pkg::*;
  logic [HW_LEVELS-1:0] level_request_line;
  logic [HW_LEVELS-1:0] level_grant_line;
  logic [HW_LEVELS-1:0] level_enable_line;
  logic [ADDR_W-1:0]    trap_addr;
  logic                 trap_valid;
  logic                 flag_clear_pulse;
  modport ctrl (input level_request_line, trap_addr, trap_valid,
                output level_grant_line, level_enable_line,
                flag_clear_pulse);
  modport dev (output level_request_line, trap_addr, trap_valid,
               input level_grant_line, level_enable_line,
               flag_clear_pulse);
endinterface

// >>> logic/device_chain_end.sv
`timescale 1ns/1ns
module device_chain_end
  import prio_chain_pkg::*;
#(
  parameter int LEVEL = 0,
  parameter int NDEV  = DEV_PER_LEVEL,
  parameter logic [NDEV*ADDR_W-1:0] ADDRS = '0
) (
  // clock and reset
  input  wire logic            clock_in,
  input  wire logic            resetn_in,
  // device flags, set by device, cleared by software
  input  wire logic [NDEV-1:0] flag_set_in,
  input  wire logic [NDEV-1:0] flag_clr_in,
  // link
  prio_chain_if.dev            bus,
  // status
  output logic      [NDEV-1:0] flag_out,
  output logic      [NDEV-1:0] served_out
);
  if (NDEV < 1 || NDEV > DEV_PER_LEVEL) begin : g_bad_ndev
    $error("ndev out of range"); // see R2
  end
  if (LEVEL < 0 || LEVEL >= HW_LEVELS) begin : g_bad_level
    $error("level out of range"); // see R6
  end
  logic [NDEV-1:0] flag_reg, flag_next, sel, taken_reg, taken_next;
  logic [NDEV:0]   grant_chain;
  logic [ADDR_W-1:0] addr;
  logic            gr, en;
  assign gr = bus.level_grant_line[LEVEL];
  assign en = bus.level_enable_line[LEVEL];
  assign grant_chain[0] = gr;
  // grant ripples down; nearest pending device absorbs it
  genvar i;
  generate
    for (i = 0; i < NDEV; i++) begin : g_dev
      assign sel[i] = grant_chain[i] & flag_reg[i]; // see R7
      assign grant_chain[i+1] = grant_chain[i] & ~flag_reg[i]; // see R16
    end
  endgenerate
  always_comb begin
    addr = '0;
    for (int k = 0; k < NDEV; k++) begin
      if (sel[k]) begin
        addr = ADDRS[k*ADDR_W +: ADDR_W]; // see R3 R8 R9 R11
      end
    end
  end
  // flags leave only by software clear; set wins over clear
  always_comb begin
    flag_next  = (flag_reg & ~flag_clr_in) | flag_set_in; // see R10 R12
    taken_next = sel;
  end
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      flag_reg  <= '0;
      taken_reg <= '0;
    end else begin
      flag_reg  <= flag_next;
      taken_reg <= taken_next;
    end
  end
  always_comb begin
    bus.level_request_line = '0;
    bus.level_request_line[LEVEL] = en & (|flag_reg); // see R6 R12
    bus.trap_addr  = addr;
    bus.trap_valid = |sel;
  end
  assign flag_out   = flag_reg;
  // the clear pulse trails the grant by a cycle, so pair it with the
  // device that took that grant
  assign served_out = taken_reg & {NDEV{bus.flag_clear_pulse}};
endmodule // device_chain_end

// >>> logic/priority_vector_unit.sv
`timescale 1ns/1ns
// Operation
// R1 - 32 channels, eight levels, four software
// R2 - up to eight devices per level
// R3 - granted device drives its trap address
// R4 - higher level preempts lower; transfers first
// R5 - one global enable, no per-channel enable; level 0 here is also gated by reader_enable_in
// R6 - per-level request, grant, enable lines
// R7 - order by level, then chain position
// R8 - six address lines, bit 40 plus channel
// R9 - nonstandard addresses may exceed octal 77; the six-bit trap_addr here stops at octal 77
// R10 - software clears flags, not the pulse
// R11 - device may gate address from register
// R12 - multi-flag request clears when flags clear
// R13 - simple devices leave by flag clear
// R14 - trap address equals channel plus 40
// R15 - this unit beats program interrupt
// R16 - device passes grant only if idle
module priority_vector_unit
  import prio_chain_pkg::*;
(
  // clock and reset
  input  wire logic                  clock_in,
  input  wire logic                  resetn_in,
  // processor side
  input  wire logic                  enable_set_in,
  input  wire logic                  enable_clr_in,
  input  wire logic [SW_LEVELS-1:0]  sw_request_in,
  input  wire logic                  debreak_in,
  input  wire logic                  transfer_busy_in,
  input  wire logic                  pi_request_in,
  input  wire logic                  reader_enable_in,
  // link
  prio_chain_if.ctrl                 bus,
  // results
  output logic                       break_out,
  output logic [ADDR_W-1:0]          vector_out,
  output logic [ALL_LEVELS-1:0]      active_out,
  output logic                       enabled_out,
  output logic                       pi_request_out
);
  typedef enum {S_IDLE, S_GRANT, S_TAKE} state_t;
  state_t state_reg, state_next;
  logic enable_reg, enable_next;
  logic [ALL_LEVELS-1:0] active_reg, active_next, req;
  logic [ALL_LEVELS-1:0] sw_pend_reg, sw_pend_next;
  logic [HW_LEVELS-1:0] lvl_en_reg, lvl_en_next;
  logic [HW_LEVELS-1:0] grant_reg, grant_next;
  logic [ADDR_W-1:0] vec_reg, vec_next;
  logic brk_reg, brk_next, clr_reg, clr_next, pi_reg, pi_next;
  logic [1:0] hold_reg, hold_next;
  logic [2:0] win, glev;
  logic       any, outranks;
  // the winner index is three bits wide and the hold counter two
  if (HW_LEVELS + SW_LEVELS != ALL_LEVELS || ALL_LEVELS > 8) begin : g_lvl
    $error("level counts do not fit the winner index"); // see R1
  end
  if (SW_CHAN_BASE + SW_LEVELS > CHANNELS) begin : g_chan
    $error("software channels run past the last channel"); // see R14
  end
  if (GRANT_HOLD < 1 || GRANT_HOLD > 3) begin : g_hold
    $error("grant hold does not fit its counter");
  end
  // request lines share this clock: a synchronised copy would lag the
  // flag clear and grant a level that has already let go
  assign req = {sw_pend_reg[ALL_LEVELS-1:HW_LEVELS],
                bus.level_request_line}; // see R1
  // lowest index is highest level
  always_comb begin
    win = '0;
    any = 1'b0;
    for (int l = ALL_LEVELS-1; l >= 0; l--) begin
      if (req[l]) begin
        win = 3'(l); // see R7
        any = 1'b1;
      end
    end
  end
  // an active level at or above the winner holds it off
  always_comb begin
    outranks = 1'b1;
    for (int l = 0; l < ALL_LEVELS; l++) begin
      if (active_reg[l] && l <= int'(win)) begin
        outranks = 1'b0; // see R4
      end
    end
    // level now granted; the winner may have moved on since
    glev = '0;
    for (int l = 0; l < HW_LEVELS; l++) begin
      if (grant_reg[l]) begin
        glev = 3'(l);
      end
    end
  end
  // next values for enable, levels, software requests and grant
  always_comb begin
    state_next   = state_reg;
    enable_next  = enable_reg;
    active_next  = active_reg;
    sw_pend_next = sw_pend_reg;
    grant_next   = grant_reg;
    vec_next     = vec_reg;
    brk_next     = 1'b0;
    clr_next     = 1'b0;
    hold_next    = hold_reg;
    if (enable_set_in) begin
      enable_next = 1'b1; // see R5
    end else if (enable_clr_in) begin
      enable_next = 1'b0; // see R5
    end
    if (debreak_in) begin
      for (int l = ALL_LEVELS-1; l >= 0; l--) begin
        if (active_reg[l]) begin
          active_next = active_reg & ~(8'h01 << l);
        end
      end
    end
    case (state_reg)
      S_IDLE: begin
        if (enable_reg && any && outranks && !transfer_busy_in) begin // see R4
          if (win < 3'(HW_LEVELS)) begin
            grant_next = 4'h1 << win[1:0]; // see R6
            hold_next  = 2'(GRANT_HOLD);
            state_next = S_GRANT;
          end else begin
            sw_pend_next[win] = 1'b0;
            active_next[win]  = 1'b1;
            vec_next = TRAP_BASE + ADDR_W'(SW_CHAN_BASE) + // see R14
                       ADDR_W'(int'(win) - HW_LEVELS);
            brk_next = 1'b1;
          end
        end
      end
      S_GRANT: begin
        if (bus.trap_valid) begin
          vec_next = bus.trap_addr; // see R3
          active_next[glev] = 1'b1;
          brk_next   = 1'b1;
          clr_next   = 1'b1;
          grant_next = '0;
          state_next = S_TAKE;
        end else if (hold_reg == 2'h0) begin
          grant_next = '0; // request withdrawn: see R12 R13
          state_next = S_TAKE;
        end else begin
          hold_next = hold_reg - 2'h1;
        end
      end
      S_TAKE: begin
        state_next = S_IDLE; // one quiet cycle before the next arbitration
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
    // a software request in the cycle its old one is taken stays pending
    for (int s = 0; s < SW_LEVELS; s++) begin
      if (sw_request_in[s]) begin
        sw_pend_next[HW_LEVELS+s] = 1'b1;
      end
    end
  end
  // flag shared with program interrupt goes nowhere while enabled
  always_comb begin
    pi_next = pi_request_in & ~enable_reg; // see R15
  end
  // reader keeps its own enable; others follow the global one
  always_comb begin
    lvl_en_next    = {HW_LEVELS{enable_next}}; // see R5
    lvl_en_next[0] = enable_next & reader_enable_in;
  end
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg   <= S_IDLE;
      enable_reg  <= 1'b0;
      active_reg  <= '0;
      sw_pend_reg <= '0;
      grant_reg   <= '0;
      vec_reg     <= '0;
      brk_reg     <= 1'b0;
      clr_reg     <= 1'b0;
      hold_reg    <= '0;
      pi_reg      <= 1'b0;
      lvl_en_reg  <= '0;
    end else begin
      state_reg   <= state_next;
      enable_reg  <= enable_next;
      active_reg  <= active_next;
      sw_pend_reg <= sw_pend_next;
      grant_reg   <= grant_next;
      vec_reg     <= vec_next;
      brk_reg     <= brk_next;
      clr_reg     <= clr_next;
      hold_reg    <= hold_next;
      pi_reg      <= pi_next;
      lvl_en_reg  <= lvl_en_next;
    end
  end
  always_comb begin
    bus.level_grant_line  = grant_reg;
    bus.level_enable_line = lvl_en_reg;
    bus.flag_clear_pulse  = clr_reg; // see R10
  end
  assign break_out      = brk_reg;
  assign vector_out     = vec_reg;
  assign active_out     = active_reg;
  assign enabled_out    = enable_reg;
  assign pi_request_out = pi_reg;
endmodule // priority_vector_unit

// >>> tb/prio_chain_properties.sv
`timescale 1ns/1ns
module prio_chain_properties
  import prio_chain_pkg::*;
(
  input wire logic                 clock_in,
  input wire logic                 resetn_in,
  input wire logic [HW_LEVELS-1:0] level_request_line,
  input wire logic [HW_LEVELS-1:0] level_grant_line,
  input wire logic [ADDR_W-1:0]    trap_addr,
  input wire logic                 trap_valid,
  input wire logic                 flag_clear_pulse
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  property p_one; $onehot0(level_grant_line); endproperty
  a_one: assert property (p_one) else $error("two grants");
  // request lines share the clock: a grant rises only on a request seen
  property p_cause; (level_grant_line & ~$past(level_grant_line)
    & ~$past(level_request_line)) == '0;
  endproperty
  a_cause: assert property (p_cause) else $error("grant early");
  property p_hold; (|level_grant_line) [*3] |=> !(|level_grant_line);
  endproperty
  a_hold: assert property (p_hold) else $error("grant long");
  property p_own; trap_valid |-> $onehot(level_grant_line
    & level_request_line); endproperty
  a_own: assert property (p_own) else $error("trap unowned");
  property p_base; trap_valid |-> trap_addr[ADDR_W-1]; endproperty
  a_base: assert property (p_base) else $error("no base bit");
  property p_drop; trap_valid |=> !(|level_grant_line); endproperty
  a_drop: assert property (p_drop) else $error("grant kept");
  property p_clr; trap_valid |=> flag_clear_pulse; endproperty
  a_clr: assert property (p_clr) else $error("no clear pulse");
  property p_clr1; flag_clear_pulse |=> !flag_clear_pulse; endproperty
  a_clr1: assert property (p_clr1) else $error("clear long");
endmodule // prio_chain_properties

// >>> tb/priority_interrupt_chain_tb.sv
`timescale 1ns/1ns
module priority_interrupt_chain_tb;
  import prio_chain_pkg::*;
  logic              clock_in, resetn_in, en_set, en_clr, dbk, busy, pi;
  logic              brk, enabled, pi_out, rd_en;
  logic [3:0]        sw;
  logic [1:0]        fset, fclr, flags, served, rot;
  logic [5:0]        vec, exp_q[$];
  logic [7:0]        active, want, want_srv;
  logic [31:0]       lfsr = 32'h5C57;
  int                err_count = 0;
  int                check_count = 0;
  prio_chain_if prio_chain_if_i();
  priority_vector_unit priority_vector_unit_i(.clock_in(clock_in),
    .resetn_in(resetn_in), .enable_set_in(en_set), .enable_clr_in(en_clr),
    .sw_request_in(sw), .debreak_in(dbk), .transfer_busy_in(busy),
    .pi_request_in(pi), .reader_enable_in(rd_en), .bus(prio_chain_if_i),
    .break_out(brk), .vector_out(vec), .active_out(active),
    .enabled_out(enabled), .pi_request_out(pi_out));
  device_chain_end #(.LEVEL(1), .NDEV(2), .ADDRS({6'h25, 6'h24}))
    device_chain_end_i(.clock_in(clock_in), .resetn_in(resetn_in),
    .flag_set_in(fset), .flag_clr_in(fclr), .bus(prio_chain_if_i),
    .flag_out(flags), .served_out(served));
  prio_chain_properties prio_chain_properties_i(.clock_in(clock_in),
    .resetn_in(resetn_in),
    .level_request_line(prio_chain_if_i.level_request_line),
    .level_grant_line(prio_chain_if_i.level_grant_line),
    .trap_addr(prio_chain_if_i.trap_addr),
    .trap_valid(prio_chain_if_i.trap_valid),
    .flag_clear_pulse(prio_chain_if_i.flag_clear_pulse));
  function automatic logic [31:0] next_lfsr(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic tick(int n);
    repeat (n) @(posedge clock_in);
    #2;
  endtask
  task automatic check(logic [7:0] seen, logic [7:0] want);
    check_count++;
    if (seen !== want) begin
      err_count++;
      $display("MISMATCH %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task automatic drain();
    for (int i = 0; i < 40 && exp_q.size() != 0; i++) tick(1);
    check(8'(exp_q.size()), 8'h00);
  endtask
  // flags first, else the level would be granted again at once
  task automatic release_level(logic [1:0] clr);
    fclr = clr;
    tick(1);
    fclr = '0;
    dbk = 1'b1;
    tick(1);
    dbk = 1'b0;
    tick(2);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // an unexpected break meets the impossible value FF
  always @(negedge clock_in) begin
    if (brk === 1'b1) begin
      want = exp_q.size() ? 8'(exp_q.pop_front()) : 8'hFF;
      want_srv = (want == 8'h24) ? 8'h01 : (want == 8'h25) ? 8'h02 : 8'h00;
      check(8'(vec), want);
      check(8'(served), want_srv);
    end
  end
  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end
  initial begin
    repeat (3000) @(posedge clock_in);
    err_count++;
    complete_run();
  end
  initial begin
    {en_set, en_clr, dbk, busy, pi, sw, fset, fclr} = '0;
    rd_en = 1'b1;
    resetn_in = 1'b0;
    tick(3);
    resetn_in = 1'b1;
    pi = 1'b1;
    fset = 2'b11;
    tick(1);
    fset = '0;
    tick(20);
    check(8'(flags), 8'h03);
    check(8'(pi_out), 8'h01);
    $display("test disabled done");
    exp_q.push_back(6'h24);
    en_set = 1'b1;
    tick(1);
    en_set = 1'b0;
    drain();
    check(8'(pi_out), 8'h00);
    check(active, 8'h02);
    exp_q.push_back(6'h25);
    release_level(2'b01);
    drain();
    sw = 4'h1;
    tick(1);
    sw = '0;
    tick(10);
    exp_q.push_back(TRAP_BASE);
    release_level(2'b10);
    drain();
    release_level(2'b00);
    check(active, 8'h00);
    $display("test order done");
    lfsr = next_lfsr(lfsr);
    rot = lfsr[1:0];
    for (int i = 0; i < SW_LEVELS; i++) begin
      busy = 1'b1;
      sw = 4'(1 << ((i + rot) % SW_LEVELS));
      tick(1);
      sw = '0;
      lfsr = next_lfsr(lfsr);
      tick(4 + lfsr[5:2]);
      exp_q.push_back(TRAP_BASE + 6'((i + rot) % SW_LEVELS));
      busy = 1'b0;
      drain();
      release_level(2'b00);
    end
    // flag cleared on the granting edge: grant times out, no break
    fset = 2'b01;
    tick(1);
    fset = '0;
    fclr = 2'b01;
    tick(1);
    fclr = '0;
    tick(6);
    check(8'(flags), 8'h00);
    check(active, 8'h00);
    $display("test withdraw done");
    rd_en = 1'b0;
    tick(1);
    check(8'(prio_chain_if_i.level_enable_line), 8'h0E);
    rd_en = 1'b1;
    en_clr = 1'b1;
    tick(2);
    en_clr = 1'b0;
    check(8'(enabled), 8'h00);
    check(8'(prio_chain_if_i.level_enable_line), 8'h00);
    $display("test software done");
    complete_run();
  end
endmodule // priority_interrupt_chain_tb
